// ==== pkg/sysctl_irq_defines.vh ====
// constants for the system-control event and oscillator monitor block
// Functional notes
// - seven event sources, each with its own status bit
// - clear mask deasserts selected sources, others keep their state
// - sources stay set until cleared, holding the interrupt pending
// - only enabled sources reach the processor interrupt line
// - enable mask sets enable bits of named sources
// - disable mask clears enable bits, raw state untouched
// - raw and masked status both readable
// - all enabled sources combine into one interrupt request
// - validate setting runs a main oscillator loss detector
// - on osc failure raise interrupt if chosen, else reset processor
// - no-crystal setting ignores osc pins and powers circuit down
// - high-speed select set routes port access to the fast aperture
// - select cleared serves port only through the slow aperture
// - each port has its own fast aperture base used when selected
// - nine selectable ports, A to H and J
// - fast-only ports become inaccessible when select cleared
// - lock source asserts when multiplier reaches lock
`ifndef SYSCTL_IRQ_DEFINES_VH
`define SYSCTL_IRQ_DEFINES_VH
// register offsets (word addresses on the byte-address bus)
`define OFS_RAW_STATUS 8'h00
`define OFS_MASKED_STATUS 8'h04
`define OFS_IRQ_CLEAR 8'h08
`define OFS_IRQ_ENABLE_SET 8'h0C
`define OFS_IRQ_ENABLE_CLR 8'h10
`define OFS_IRQ_ENABLE 8'h14
`define OFS_OSC_CONFIG 8'h18
`define OFS_PORT_SELECT 8'h1C
`define OFS_OSC_STATUS 8'h20
// source bit positions
`define BIT_MULT_LOCK 0
`define BIT_CUR_LIMIT 1
`define BIT_INT_OSC_FAIL 2
`define BIT_MAIN_OSC_FAIL 3
`define BIT_INT_DROOP 4
`define BIT_EXT_DROOP 5
`define BIT_MULT_FAIL 6
`define NUM_SRC 7
// oscillator configuration bits
`define BIT_VALIDATE 0
`define BIT_FAIL_TO_IRQ 1
`define BIT_NO_CRYSTAL 2
// port select count and reset values
`define NUM_PORTS 9
`define RST_ENABLE 7'h00
`define RST_OSC_CFG 3'h0
`define RST_PORT_SEL 9'h000
// oscillator monitor timing: loss if no edge within this time
`define OSC_TIMEOUT_NS 1000
`define CLK_PERIOD_NS 40
`define OSC_TIMEOUT_CYC (`OSC_TIMEOUT_NS / `CLK_PERIOD_NS)
// reset pulse length toward the processor
`define CPU_RST_CYC 5'h10
`endif

// ==== design/osc_monitor.v ====
// main oscillator loss detector with synchronised sample pin
`timescale 1ns/1ps
`include "sysctl_irq_defines.vh"
module osc_monitor #(
   parameter TIMEOUT = `OSC_TIMEOUT_CYC
) (
   // clock and reset
   input wire mclk_i,
   input wire nrst_i,
   // control
   input wire enable_i,
   // oscillator sample from pin
   input wire osc_clk_i,
   // loss pulse
   output reg fail_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;
   reg [15:0] cnt_q;
   reg armed_q;
   wire edge_seen;

   assign edge_seen = (s2_q == s3_q) && (s3_q != lvl_q);

   // three-stage synchroniser; change counts when stage 2 and 3 agree
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= osc_clk_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;
         end
      end
   end

   // watchdog on oscillator edges while validation is on
   always @(posedge mclk_i) begin
      if (!nrst_i || !enable_i) begin
         cnt_q <= 16'h0000;
         armed_q <= 1'b1;
         fail_o <= 1'b0;
      end else begin
         fail_o <= 1'b0;
         if (edge_seen) begin
            cnt_q <= 16'h0000;
            armed_q <= 1'b1;
         end else if (cnt_q >= TIMEOUT[15:0] - 16'h0001) begin
            fail_o <= armed_q;
            armed_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule

// ==== design/port_aperture.v ====
// gpio port aperture steering between slow and fast buses
`timescale 1ns/1ps
`include "sysctl_irq_defines.vh"
module port_aperture #(
   parameter NPORT = `NUM_PORTS,
   parameter [NPORT-1:0] FAST_ONLY = 9'h000
) (
   // per-port select
   input wire [NPORT-1:0] sel_i,
   // per-port aperture enables
   output wire [NPORT-1:0] slow_en_o,
   output wire [NPORT-1:0] fast_en_o
);
   genvar g;
   generate
      for (g = 0; g < NPORT; g = g + 1) begin : g_port
         // fast when selected, slow otherwise unless port is fast-only
         assign fast_en_o[g] = sel_i[g];
         assign slow_en_o[g] = ~sel_i[g] & ~FAST_ONLY[g];
      end
   endgenerate
endmodule

// ==== design/sysctl_irq_top.v ====
// system-control event sources, interrupt mask and oscillator monitor
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "sysctl_irq_defines.vh"
module sysctl_irq_top #(
   parameter OSC_TIMEOUT = `OSC_TIMEOUT_CYC,
   parameter [`NUM_PORTS-1:0] FAST_ONLY = 9'h000
) (
   // clock and reset
   input wire mclk_i,
   input wire nrst_i,
   // register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // event inputs from same-clock logic
   input wire mult_locked_i,
   input wire regulator_current_limit_i,
   input wire internal_osc_fail_i,
   input wire internal_supply_droop_i,
   input wire external_supply_droop_i,
   input wire mult_fail_i,
   // main oscillator sample (pin)
   input wire main_oscillator_i,
   // interrupt and reset toward processor
   output wire sysctl_irq_o,
   output reg cpu_reset_o,
   // oscillator power control
   output wire main_osc_power_down_o,
   // gpio aperture enables
   output wire [`NUM_PORTS-1:0] slow_aperture_en_o,
   output wire [`NUM_PORTS-1:0] fast_aperture_en_o
);
   reg [`NUM_SRC-1:0] raw_q;
   reg [`NUM_SRC-1:0] en_q;
   reg [2:0] osc_cfg_q;
   reg [`NUM_PORTS-1:0] port_sel_q;
   reg lock_prev_q;
   reg osc_failed_q;
   reg [4:0] rst_cnt_q;
   reg [`NUM_SRC-1:0] set_d;
   reg [`NUM_SRC-1:0] clr_d;
   wire osc_fail;
   wire validate;
   wire no_crystal;
   wire [`NUM_SRC-1:0] masked;

   // address compare, used by every register access
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   assign validate = osc_cfg_q[`BIT_VALIDATE];
   assign no_crystal = osc_cfg_q[`BIT_NO_CRYSTAL];
   assign main_osc_power_down_o = no_crystal;

   // loss detector runs only when validating with a crystal present
   osc_monitor #(
      .TIMEOUT(OSC_TIMEOUT)
   ) u_osc_monitor (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .enable_i(validate & ~no_crystal),
      .osc_clk_i(main_oscillator_i),
      .fail_o(osc_fail)
   );

   // per-port bus aperture steering
   port_aperture #(
      .NPORT(`NUM_PORTS),
      .FAST_ONLY(FAST_ONLY)
   ) u_port_aperture (
      .sel_i(port_sel_q),
      .slow_en_o(slow_aperture_en_o),
      .fast_en_o(fast_aperture_en_o)
   );

   // event set terms from sources, rising lock and oscillator failure
   always @* begin
      set_d = {`NUM_SRC{1'b0}};
      set_d[`BIT_MULT_LOCK] = mult_locked_i & ~lock_prev_q;
      set_d[`BIT_CUR_LIMIT] = regulator_current_limit_i;
      set_d[`BIT_INT_OSC_FAIL] = internal_osc_fail_i;
      set_d[`BIT_MAIN_OSC_FAIL] = osc_fail & osc_cfg_q[`BIT_FAIL_TO_IRQ];
      set_d[`BIT_INT_DROOP] = internal_supply_droop_i;
      set_d[`BIT_EXT_DROOP] = external_supply_droop_i;
      set_d[`BIT_MULT_FAIL] = mult_fail_i;
   end

   // write-one-to-clear mask from software
   always @* begin
      clr_d = {`NUM_SRC{1'b0}};
      if (wr_i && hit(addr_i, `OFS_IRQ_CLEAR)) begin
         clr_d = wdata_i[`NUM_SRC-1:0];
      end
   end

   // sticky raw status; a set in the clear cycle wins
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         raw_q <= {`NUM_SRC{1'b0}};
         lock_prev_q <= 1'b0;
      end else begin
         raw_q <= (raw_q & ~clr_d) | set_d;
         lock_prev_q <= mult_locked_i;
      end
   end

   // enable mask, configuration and port selects
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         en_q <= `RST_ENABLE;
         osc_cfg_q <= `RST_OSC_CFG;
         port_sel_q <= `RST_PORT_SEL;
      end else if (wr_i) begin
         if (hit(addr_i, `OFS_IRQ_ENABLE_SET)) begin
            en_q <= en_q | wdata_i[`NUM_SRC-1:0];
         end else if (hit(addr_i, `OFS_IRQ_ENABLE_CLR)) begin
            en_q <= en_q & ~wdata_i[`NUM_SRC-1:0];
         end else if (hit(addr_i, `OFS_IRQ_ENABLE)) begin
            en_q <= wdata_i[`NUM_SRC-1:0];
         end else if (hit(addr_i, `OFS_OSC_CONFIG)) begin
            osc_cfg_q <= wdata_i[2:0];
         end else if (hit(addr_i, `OFS_PORT_SELECT)) begin
            port_sel_q <= wdata_i[`NUM_PORTS-1:0];
         end
      end
   end

   // masked view and single combined request
   assign masked = raw_q & en_q;
   assign sysctl_irq_o = |masked;

   // oscillator failure without interrupt choice resets the processor
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         rst_cnt_q <= 5'h00;
         cpu_reset_o <= 1'b0;
         osc_failed_q <= 1'b0;
      end else begin
         if (osc_fail) begin
            osc_failed_q <= 1'b1;
         end
         if (osc_fail && !osc_cfg_q[`BIT_FAIL_TO_IRQ]) begin
            rst_cnt_q <= `CPU_RST_CYC;
            cpu_reset_o <= 1'b1;
         end else if (rst_cnt_q != 5'h00) begin
            rst_cnt_q <= rst_cnt_q - 5'h01;
            cpu_reset_o <= (rst_cnt_q != 5'h01);
         end else begin
            cpu_reset_o <= 1'b0;
         end
      end
   end

   // read data, one cycle after the read strobe; unmapped reads zero
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         if (hit(addr_i, `OFS_RAW_STATUS)) begin
            rdata_o <= {25'h0, raw_q};
         end else if (hit(addr_i, `OFS_MASKED_STATUS)) begin
            rdata_o <= {25'h0, masked};
         end else if (hit(addr_i, `OFS_IRQ_ENABLE)) begin
            rdata_o <= {25'h0, en_q};
         end else if (hit(addr_i, `OFS_OSC_CONFIG)) begin
            rdata_o <= {29'h0, osc_cfg_q};
         end else if (hit(addr_i, `OFS_PORT_SELECT)) begin
            rdata_o <= {23'h0, port_sel_q};
         end else if (hit(addr_i, `OFS_OSC_STATUS)) begin
            rdata_o <= {31'h0, osc_failed_q};
         end else begin
            rdata_o <= 32'h00000000;
         end
      end else begin
         rdata_o <= 32'h00000000;
      end
   end
endmodule

// ==== testbench/osc_source.sv ====
// main oscillator source model driving the sampled oscillator pin
`timescale 1ns/1ps
module osc_source (
   input wire mclk_i,
   input wire run_i,
   output reg osc_o
);
   reg div_q;
   initial begin
      div_q = 1'b0;
      osc_o = 1'b0;
   end
   // toggles every two cycles; a stopped source freezes like a dead crystal
   always @(posedge mclk_i) begin
      div_q <= run_i ? ~div_q : div_q;
      if (run_i && div_q)
         osc_o <= ~osc_o;
   end
endmodule

// ==== testbench/sysctl_irq_chk.sv ====
// port assertions for the system-control event block
`timescale 1ns/1ps
module sysctl_irq_chk #(
   parameter OSC_TIMEOUT = 25,
   parameter [8:0] FAST_ONLY = 9'h000
) (
   input wire mclk_i,
   input wire nrst_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire mult_locked_i,
   input wire regulator_current_limit_i,
   input wire internal_osc_fail_i,
   input wire internal_supply_droop_i,
   input wire external_supply_droop_i,
   input wire mult_fail_i,
   input wire sysctl_irq_o,
   input wire cpu_reset_o,
   input wire main_osc_power_down_o,
   input wire [8:0] slow_aperture_en_o,
   input wire [8:0] fast_aperture_en_o
);
   // no level source is setting a raw bit this cycle
   wire quiet = !(regulator_current_limit_i | internal_osc_fail_i |
      internal_supply_droop_i | external_supply_droop_i | mult_fail_i);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence hi8;
      cpu_reset_o [*8];
   endsequence
   a_rdata_idle:
      assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read slot");
   a_mask_read:
      assert property (rd_i && addr_i == 8'h04 |=>
         (rdata_o != 32'h0) == $past(sysctl_irq_o))
      else $error("masked status disagrees with irq");
   a_irq_hold:
      assert property (sysctl_irq_o && !(wr_i &&
         addr_i inside {8'h08, 8'h10, 8'h14}) |=> sysctl_irq_o)
      else $error("irq dropped without clear or disable");
   a_clear_all:
      assert property (wr_i && addr_i == 8'h08 && wdata_i[6:0] == 7'h7F
         && quiet && !$rose(mult_locked_i) |=> !sysctl_irq_o)
      else $error("irq stays after clearing all");
   a_disable_all:
      assert property (wr_i && addr_i == 8'h10 && wdata_i[6:0] == 7'h7F
         |=> !sysctl_irq_o)
      else $error("irq with all sources disabled");
   a_sel_fast:
      assert property (wr_i && addr_i == 8'h1C |=>
         fast_aperture_en_o == $past(wdata_i[8:0]))
      else $error("fast aperture not following select");
   a_slow_pair:
      assert property (slow_aperture_en_o ==
         (~fast_aperture_en_o & ~FAST_ONLY))
      else $error("slow aperture not complement of fast");
   a_pwr_down:
      assert property (wr_i && addr_i == 8'h18 |=>
         main_osc_power_down_o == $past(wdata_i[2]))
      else $error("power down not following config");
   a_rst_len:
      assert property ($rose(cpu_reset_o) |-> hi8 ##1 hi8 ##1 !cpu_reset_o)
      else $error("processor reset pulse length wrong");
endmodule
bind sysctl_irq_top sysctl_irq_chk #(.OSC_TIMEOUT(OSC_TIMEOUT),
   .FAST_ONLY(FAST_ONLY)) sysctl_irq_chk_i (.mclk_i, .nrst_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .mult_locked_i,
   .regulator_current_limit_i, .internal_osc_fail_i,
   .internal_supply_droop_i, .external_supply_droop_i, .mult_fail_i,
   .sysctl_irq_o, .cpu_reset_o, .main_osc_power_down_o,
   .slow_aperture_en_o, .fast_aperture_en_o);

// ==== testbench/sysctl_irq_top_tb.sv ====
// self-checking bench for the system-control event block
`timescale 1ns/1ps
module sysctl_irq_top_tb;
   localparam OT = 8;
   // ports H and J exist only on the fast bus in this bench
   localparam [8:0] FO = 9'h180;
   reg mclk_i, nrst_i, wr_i, rd_i, run;
   reg [7:0] addr_i;
   reg [31:0] wdata_i;
   reg [6:0] ev;
   wire [31:0] rdata_o;
   wire irq, cpu_rst, pd, osc;
   wire [8:0] slow, fast;
   integer fails = 0, n_checks = 0, i, n;
   sysctl_irq_top #(.OSC_TIMEOUT(OT), .FAST_ONLY(FO)) sysctl_irq_top_i (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .mult_locked_i(ev[0]),
      .regulator_current_limit_i(ev[1]), .internal_osc_fail_i(ev[2]),
      .internal_supply_droop_i(ev[4]), .external_supply_droop_i(ev[5]),
      .mult_fail_i(ev[6]), .main_oscillator_i(osc), .sysctl_irq_o(irq),
      .cpu_reset_o(cpu_rst), .main_osc_power_down_o(pd),
      .slow_aperture_en_o(slow), .fast_aperture_en_o(fast));
   osc_source osc_source_i (.mclk_i(mclk_i), .run_i(run), .osc_o(osc));
   task chk(input string nm, input [31:0] e, input [31:0] g);
      n_checks = n_checks + 1;
      if (e !== g) begin
         fails = fails + 1;
         $display("unexpected %0s exp %h got %h", nm, e, g);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk("rdata", e, rdata_o);
   endtask
   task pulse(input [6:0] m);
      @(posedge mclk_i);
      ev <= m;
      @(posedge mclk_i);
      ev <= 7'h00;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // reset values and an unmapped read
   task t_reset;
      rd(8'h14, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h1C, 32'h0);
      rd(8'h3C, 32'h0);
      wr(8'h00, 32'h7F);
      rd(8'h00, 32'h0);
      chk("irq", 32'h0, irq);
      chk("fast", 32'h0, fast);
      chk("slow", {23'h0, ~FO}, slow);
   endtask
   // each source except main oscillator failure (bit 3) sets, holds through a foreign clear, then clears
   task t_sources;
      wr(8'h0C, 32'h7F);
      for (i = 0; i < 7; i = i + 1) begin
         if (i != 3) begin
            pulse(7'h01 << i);
            rd(8'h00, 32'h1 << i);
            chk("irq", 32'h1, irq);
            wr(8'h08, ~(32'h1 << i) & 32'h7F);
            rd(8'h00, 32'h1 << i);
            wr(8'h08, 32'h1 << i);
            rd(8'h00, 32'h0);
            chk("irq", 32'h0, irq);
         end
      end
   endtask
   // enable mask against raw and masked views
   task t_mask;
      pulse(7'h42);
      wr(8'h10, 32'h02);
      rd(8'h04, 32'h40);
      rd(8'h14, 32'h7D);
      chk("irq", 32'h1, irq);
      wr(8'h10, 32'h7F);
      chk("irq", 32'h0, irq);
      rd(8'h00, 32'h42);
      rd(8'h04, 32'h0);
      wr(8'h08, 32'h7F);
      wr(8'h14, 32'h15);
      rd(8'h14, 32'h15);
      wr(8'h0C, 32'h7F);
      rd(8'h14, 32'h7F);
   endtask
   // walk one select through all nine ports
   task t_ports;
      for (i = 0; i < 9; i = i + 1) begin
         wr(8'h1C, 32'h1 << i);
         chk("fast", 32'h1 << i, fast);
         chk("slow", {23'h0, ~(9'h001 << i) & ~FO}, slow);
      end
      rd(8'h1C, 32'h100);
      wr(8'h1C, 32'h0);
      chk("slow", {23'h0, ~FO}, slow);
   endtask
   // oscillator loss: interrupt mode, then processor reset mode
   task t_osc;
      @(posedge mclk_i);
      run <= 1'b1;
      wr(8'h18, 32'h3);
      repeat (30) @(posedge mclk_i);
      rd(8'h00, 32'h0);
      @(posedge mclk_i);
      run <= 1'b0;
      repeat (OT + 12) @(posedge mclk_i);
      rd(8'h00, 32'h8);
      rd(8'h20, 32'h1);
      chk("irq", 32'h1, irq);
      chk("cpu_rst", 32'h0, cpu_rst);
      @(posedge mclk_i);
      run <= 1'b1;
      repeat (12) @(posedge mclk_i);
      wr(8'h08, 32'h8);
      wr(8'h18, 32'h1);
      @(posedge mclk_i);
      run <= 1'b0;
      n = 0;
      repeat (OT + 40) begin
         @(posedge mclk_i);
         #1;
         n = n + cpu_rst;
      end
      chk("rst_len", 32'h10, n);
      rd(8'h00, 32'h0);
      wr(8'h18, 32'h4);
      chk("pwr_dn", 32'h1, pd);
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // hang guard well beyond the expected few hundred cycles
   initial begin
      #200000;
      fails = fails + 1;
      close_out;
   end
   initial begin
      nrst_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      ev = 7'h00;
      run = 1'b0;
      repeat (20) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_sources;
      t_mask;
      t_ports;
      t_osc;
      close_out;
   end
endmodule
